// ===== core/tbw_top.sv
// time base prescaler with interval flag, taps and watchdog control
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tbw_top (
  // clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        reset_in,
  // register port
  input  wire logic [tbw_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [tbw_pkg::DATA_W-1:0]  reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic      [tbw_pkg::DATA_W-1:0]  reg_rdata_out,
  // watch timer taps from the sub clock domain
  input  wire logic [3:0]                  wt_tap_in,
  // interrupt and reset to the cpu
  output logic                             prescaler_irq_out,
  output logic      [7:0]                  prescaler_irq_num_out,
  output logic                             cpu_reset_out,
  // clock taps and watchdog status for other peripherals
  output logic      [tbw_pkg::CNT_W-1:0]   pre_taps_out,
  output logic                             wd_active_out
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  tbw_if wd ();

  logic [tbw_pkg::CNT_W-1:0] cnt_ff;
  logic                      phase_ff;
  logic                      adv;
  logic                      ovf_evt;
  logic [1:0]                pre_sel_ff;
  logic                      irq_en_ff;
  logic                      ovf_flag_ff;
  logic                      irq_ff;
  logic [7:0]                irq_num_ff;
  logic                      wd_src_ff;
  logic [1:0]                wd_sel_ff;
  logic                      cpu_rst_ff;
  logic                      wd_act_ff;
  logic [tbw_pkg::DATA_W-1:0] rdata_ff;
  logic [tbw_pkg::DATA_W-1:0] nxt_rdata;
  logic [3:0]                wt_meta_ff;
  logic [3:0]                wt_sync_ff;
  logic [3:0]                wt_prev_ff;
  logic                      wr_pre;
  logic                      wr_sub;
  logic                      wr_wd;
  logic                      pre_clr;

  // ****************************************************************
  // write decode
  // ****************************************************************
  assign wr_pre  = reg_wr_in && reg_addr_in == tbw_pkg::ADDR_PRE_CTRL;
  assign wr_sub  = reg_wr_in && reg_addr_in == tbw_pkg::ADDR_SUB_CTRL;
  assign wr_wd   = reg_wr_in && reg_addr_in == tbw_pkg::ADDR_WD_CTRL;
  assign pre_clr = wr_pre && reg_wdata_in[tbw_pkg::PC_CLR];

  // ****************************************************************
  // prescaler counter
  // ****************************************************************
  // the counter moves on every second core clock
  assign adv = phase_ff;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      phase_ff <= 1'b0;
    end else if (pre_clr) begin
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= ~phase_ff;
    end
  end

  // a clear restarts every tap, so a watchdog fed from here
  // sees its next tick late
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cnt_ff <= '0;
    end else if (pre_clr) begin
      cnt_ff <= '0;
    end else if (adv) begin
      cnt_ff <= cnt_ff + 18'h1;
    end
  end

  // ****************************************************************
  // interval overflow and interrupt
  // ****************************************************************
  assign ovf_evt = adv && !pre_clr
                   && tbw_pkg::carry_out(cnt_ff, tbw_pkg::ovf_bit(pre_sel_ff));

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pre_sel_ff <= tbw_pkg::PC_SEL_RST;
      irq_en_ff  <= tbw_pkg::IRQ_EN_RST;
    end else if (wr_pre) begin
      pre_sel_ff <= reg_wdata_in[tbw_pkg::PC_SEL_HI:tbw_pkg::PC_SEL_LO];
      irq_en_ff  <= reg_wdata_in[tbw_pkg::PC_IRQ_EN];
    end
  end

  // set beats a same-cycle software clear; writing one leaves it alone
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ovf_flag_ff <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_ff <= 1'b1;
    end else if (wr_pre && !reg_wdata_in[tbw_pkg::PC_OVF]) begin
      ovf_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= ovf_flag_ff && irq_en_ff;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_num_ff <= tbw_pkg::PRE_IRQ_NUM;
    end else begin
      irq_num_ff <= tbw_pkg::PRE_IRQ_NUM;
    end
  end

  // ****************************************************************
  // watch timer tap synchroniser
  // ****************************************************************
  // each tap moves slowly, so bitwise synchronising is safe
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      wt_meta_ff <= 4'h0;
      wt_sync_ff <= 4'h0;
      wt_prev_ff <= 4'h0;
    end else begin
      wt_meta_ff <= wt_tap_in;
      wt_sync_ff <= wt_meta_ff;
      wt_prev_ff <= wt_sync_ff;
    end
  end

  // ****************************************************************
  // watchdog control
  // ****************************************************************
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      wd_src_ff <= tbw_pkg::WD_SRC_RST;
    end else if (wr_sub) begin
      // software must hold zero here while running on the sub clock
      wd_src_ff <= reg_wdata_in[tbw_pkg::SC_WD_SRC];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      wd_sel_ff <= tbw_pkg::WD_SEL_RST;
    end else if (wr_wd) begin
      wd_sel_ff <= reg_wdata_in[tbw_pkg::WC_SEL_HI:tbw_pkg::WC_SEL_LO];
    end
  end

  always_comb begin
    for (int unsigned i = 0; i < 4; i++) begin
      wd.pre_tick[i] = adv && !pre_clr
                       && tbw_pkg::carry_out(cnt_ff, tbw_pkg::wd_bit(2'(i)));
    end
  end

  // rising edge of a watch timer tap is one half watchdog tick
  assign wd.sub_tick = wt_sync_ff & ~wt_prev_ff;
  assign wd.src      = wd_src_ff;
  assign wd.sel      = wd_sel_ff;
  assign wd.kick     = wr_wd && reg_wdata_in[tbw_pkg::WC_KICK];

  tbw_wdog tbw_wdog_inst (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .wd          (wd)
  );

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cpu_rst_ff <= 1'b0;
      wd_act_ff  <= 1'b0;
    end else begin
      cpu_rst_ff <= wd.fire;
      wd_act_ff  <= wd.active;
    end
  end

  // ****************************************************************
  // register read
  // ****************************************************************
  always_comb begin
    nxt_rdata = '0;
    unique case (reg_addr_in)
      tbw_pkg::ADDR_PRE_CTRL: begin
        nxt_rdata[tbw_pkg::PC_SEL_HI:tbw_pkg::PC_SEL_LO] = pre_sel_ff;
        nxt_rdata[tbw_pkg::PC_IRQ_EN] = irq_en_ff;
        nxt_rdata[tbw_pkg::PC_OVF]    = ovf_flag_ff;
      end
      tbw_pkg::ADDR_SUB_CTRL: begin
        nxt_rdata[tbw_pkg::SC_WD_SRC] = wd_src_ff;
      end
      tbw_pkg::ADDR_WD_CTRL: begin
        nxt_rdata[tbw_pkg::WC_SEL_HI:tbw_pkg::WC_SEL_LO] = wd_sel_ff;
        nxt_rdata[tbw_pkg::WC_ACTIVE] = wd.active;
        nxt_rdata[tbw_pkg::WC_CNT_HI:tbw_pkg::WC_CNT_LO] = wd.count;
      end
      tbw_pkg::ADDR_PRE_CNT: begin
        nxt_rdata = cnt_ff[tbw_pkg::CNT_W-1:tbw_pkg::PRE_CNT_RD_LO];
      end
    endcase
  end

  // data are valid only in the cycle after the read strobe
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rdata_ff <= '0;
    end else if (reg_rd_in) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata_out         = rdata_ff;
  assign prescaler_irq_out     = irq_ff;
  assign prescaler_irq_num_out = irq_num_ff;
  assign cpu_reset_out         = cpu_rst_ff;
  assign pre_taps_out          = cnt_ff;
  assign wd_active_out         = wd_act_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_count_every_two: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !pre_clr [*4] |-> cnt_ff == $past(cnt_ff, 2) + 18'h1)
    else $error("prescaler did not advance once per two clocks");

  a_ovf_shortest: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ovf_evt && pre_sel_ff == 2'h0 |-> cnt_ff[10:0] == 11'h7FF)
    else $error("shortest interval did not end on bit ten carry");

  a_ovf_longest: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ovf_evt && pre_sel_ff == 2'h3 |=> cnt_ff == 18'h0)
    else $error("longest interval did not end at counter wrap");

  a_flag_sets: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ovf_evt |=> ovf_flag_ff)
    else $error("overflow did not set the flag");

  a_irq_follows: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ovf_evt && irq_en_ff && !wr_pre |=> ##1 prescaler_irq_out)
    else $error("enabled overflow raised no interrupt");

  a_irq_masked: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !$past(irq_en_ff) |-> !prescaler_irq_out)
    else $error("interrupt raised while disabled");

  a_irq_number: assert property (@(posedge core_clk_in) disable iff (reset_in)
    prescaler_irq_out |-> prescaler_irq_num_out == 8'h10)
    else $error("wrong interrupt request number");

  a_tap_clear: assert property (@(posedge core_clk_in) disable iff (reset_in)
    pre_clr |=> pre_taps_out == 18'h0 ##1 pre_taps_out == 18'h0)
    else $error("prescaler clear did not restart the taps");

  a_reset_pulse: assert property (@(posedge core_clk_in) disable iff (reset_in)
    wd.fire |=> cpu_reset_out ##1 !cpu_reset_out)
    else $error("watchdog expiry gave no single reset pulse");

  a_pre_source: assert property (@(posedge core_clk_in) disable iff (reset_in)
    wd.src && wd.pre_tick[wd.sel] |-> adv)
    else $error("prescaler tick outside an advance");

  a_read_data: assert property (@(posedge core_clk_in) disable iff (reset_in)
    reg_rd_in && reg_addr_in == tbw_pkg::ADDR_PRE_CNT |=>
      reg_rdata_out == $past(cnt_ff[17:10]))
    else $error("counter read back wrong");

endmodule
`default_nettype wire

// ===== pkg/tbw_pkg.sv
// constants, field layout and helper functions of the time base and watchdog
package tbw_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned CNT_W  = 18;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 2;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [1:0] ADDR_PRE_CTRL = 2'h0;
  localparam logic [1:0] ADDR_SUB_CTRL = 2'h1;
  localparam logic [1:0] ADDR_WD_CTRL  = 2'h2;
  localparam logic [1:0] ADDR_PRE_CNT  = 2'h3;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned PC_SEL_LO = 0;
  localparam int unsigned PC_SEL_HI = 1;
  localparam int unsigned PC_IRQ_EN = 2;
  localparam int unsigned PC_OVF    = 3;
  localparam int unsigned PC_CLR    = 4;
  localparam int unsigned SC_WD_SRC = 0;
  localparam int unsigned WC_SEL_LO = 0;
  localparam int unsigned WC_SEL_HI = 1;
  localparam int unsigned WC_KICK   = 2;
  localparam int unsigned WC_ACTIVE = 3;
  localparam int unsigned WC_CNT_LO = 4;
  localparam int unsigned WC_CNT_HI = 5;
  localparam int unsigned PRE_CNT_RD_LO = 10;

  // ****************************************************************
  // reset values and fixed codes
  // ****************************************************************
  localparam logic [1:0] PC_SEL_RST = 2'h0;
  localparam logic       IRQ_EN_RST = 1'h0;
  localparam logic       WD_SRC_RST = 1'h1;
  localparam logic [1:0] WD_SEL_RST = 2'h0;
  localparam logic [1:0] WD_LAST    = 2'h3;
  localparam logic [7:0] PRE_IRQ_NUM = 8'h10;
  localparam logic [1:0] SRC_PRESCALER = 2'h1;

  // ****************************************************************
  // tap decoding
  // ****************************************************************
  // counter bit whose carry marks the prescaler interval
  function automatic int unsigned ovf_bit(input logic [1:0] sel);
    unique case (sel)
      2'h0: ovf_bit = 10;
      2'h1: ovf_bit = 12;
      2'h2: ovf_bit = 14;
      2'h3: ovf_bit = 17;
    endcase
  endfunction

  // half watchdog tick: eight of them make one watchdog period
  function automatic int unsigned wd_bit(input logic [1:0] sel);
    unique case (sel)
      2'h0: wd_bit = 9;
      2'h1: wd_bit = 11;
      2'h2: wd_bit = 13;
      2'h3: wd_bit = 16;
    endcase
  endfunction

  // true when all counter bits up to and including b are ones
  function automatic logic carry_out(input logic [CNT_W-1:0] c,
                                     input int unsigned b);
    logic ok;
    ok = 1'b1;
    for (int unsigned i = 0; i < CNT_W; i++) begin
      if (i <= b && !c[i]) begin
        ok = 1'b0;
      end
    end
    carry_out = ok;
  endfunction

endpackage

// ===== pkg/tbw_if.sv
// tick and status signals between the time base and its watchdog
`timescale 1ns/1ps
`default_nettype none
interface tbw_if;
  logic [3:0] pre_tick;
  logic [3:0] sub_tick;
  logic       src;
  logic [1:0] sel;
  logic       kick;
  logic       fire;
  logic       active;
  logic [1:0] count;

  modport top (
    output pre_tick, sub_tick, src, sel, kick,
    input  fire, active, count
  );
  modport wdog (
    input  pre_tick, sub_tick, src, sel, kick,
    output fire, active, count
  );
endinterface
`default_nettype wire

// ===== core/tbw_wdog.sv
// watchdog counter with source and interval selection
`timescale 1ns/1ps
`default_nettype none
module tbw_wdog (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  // link to the time base
  tbw_if.wdog       wd
);

  // ****************************************************************
  // tick selection
  // ****************************************************************
  logic        tick;
  logic        half_ff;
  logic [1:0]  cnt_ff;
  logic        active_ff;
  logic        fire_ff;
  logic [21:0] since_ff;

  always_comb begin
    // a zero source bit hands the watchdog to the watch timer
    tick = wd.src ? wd.pre_tick[wd.sel] : wd.sub_tick[wd.sel];
    if (!wd.src) begin
      tick = wd.sub_tick[wd.sel];
    end
  end

  // ****************************************************************
  // counter
  // ****************************************************************
  // the half stage doubles the 2-bit range; clearing it with the kick
  // makes the first tick phase the only source of spread
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      half_ff   <= 1'b0;
      cnt_ff    <= 2'h0;
      active_ff <= 1'b0;
    end else if (wd.kick) begin
      half_ff   <= 1'b0;
      cnt_ff    <= 2'h0;
      active_ff <= 1'b1;
    end else if (active_ff && tick) begin
      half_ff <= ~half_ff;
      if (half_ff) begin
        if (cnt_ff == tbw_pkg::WD_LAST) begin
          active_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      fire_ff <= 1'b0;
    end else begin
      fire_ff <= !wd.kick && active_ff && tick && half_ff
                 && cnt_ff == tbw_pkg::WD_LAST;
    end
  end

  // cycles since the last kick, only for the timing check
  always_ff @(posedge core_clk_in) begin
    if (reset_in || wd.kick) begin
      since_ff <= 22'h0;
    end else if (since_ff != 22'h3FFFFF) begin
      since_ff <= since_ff + 22'h1;
    end
  end

  assign wd.fire   = fire_ff;
  assign wd.active = active_ff;
  assign wd.count  = cnt_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_fire_window0: assert property (@(posedge core_clk_in) disable iff (reset_in)
    fire_ff && wd.src && wd.sel == 2'h0 && $stable(wd.sel) |->
      since_ff >= 22'h3800 && since_ff <= 22'h4800)
    else $error("watchdog fired outside the shortest prescaler window");
  a_fire_stops: assert property (@(posedge core_clk_in) disable iff (reset_in)
    fire_ff |-> !active_ff && $past(cnt_ff) == 2'h3)
    else $error("watchdog fired without reaching its last count");
  a_kick_clears: assert property (@(posedge core_clk_in) disable iff (reset_in)
    wd.kick |=> active_ff && cnt_ff == 2'h0 && !half_ff ##1 !fire_ff)
    else $error("kick did not restart the watchdog");
  a_sub_source: assert property (@(posedge core_clk_in) disable iff (reset_in)
    active_ff && !wd.kick && !wd.src && !wd.sub_tick[wd.sel] |=> $stable(half_ff))
    else $error("watchdog counted without a watch timer tick");

endmodule
`default_nettype wire

// ===== testbench/tbw_cpu_model.sv
// processor core and watch timer model at the far side of the time base and watchdog
`timescale 1ns/1ps
`default_nettype none
module tbw_cpu_model (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  // requests from the block
  input  wire logic       irq_in,
  input  wire logic [7:0] irq_num_in,
  input  wire logic       cpu_reset_in,
  // watch timer taps and event counts
  output logic      [3:0] wt_tap_out,
  output var int          resets_seen_out,
  output var int          irqs_seen_out
);
  logic [10:0] wt_cnt_ff = 11'h000;
  logic        irq_d_ff  = 1'b0;

  // ****************************************************************
  // watch timer
  // ****************************************************************
  // runs from the core clock with no reset, so the core reset never clears it
  always_ff @(posedge core_clk_in) begin
    wt_cnt_ff <= wt_cnt_ff + 11'h001;
  end
  // tap periods 64, 512, 1024, 2048 keep the 1:8:16:32 spacing of the real taps
  assign wt_tap_out = {wt_cnt_ff[10], wt_cnt_ff[9], wt_cnt_ff[8], wt_cnt_ff[5]};

  // ****************************************************************
  // core side
  // ****************************************************************
  always_ff @(posedge core_clk_in) begin
    irq_d_ff <= irq_in;
    if (reset_in) begin
      resets_seen_out <= 0;
      irqs_seen_out   <= 0;
    end else begin
      // a pulse held longer than one cycle counts more than once, which the bench catches
      if (cpu_reset_in) begin
        resets_seen_out <= resets_seen_out + 1;
      end
      if (irq_in && !irq_d_ff && irq_num_in == 8'h10) begin
        irqs_seen_out <= irqs_seen_out + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tbw_tb_top.sv
// self-checking bench for the time base and watchdog
`timescale 1ns/1ps
`default_nettype none
module tbw_tb_top;
  logic        core_clk_in   = 1'b0;
  logic        reset_in      = 1'b1;
  logic [1:0]  reg_addr_in   = 2'h0;
  logic [7:0]  reg_wdata_in  = 8'h00;
  logic        reg_wr_in     = 1'b0;
  logic        reg_rd_in     = 1'b0;
  logic [7:0]  reg_rdata_out;
  logic [3:0]  wt_tap_in;
  logic        prescaler_irq_out;
  logic [7:0]  prescaler_irq_num_out;
  logic        cpu_reset_out;
  logic [17:0] pre_taps_out;
  logic        wd_active_out;
  int          resets_seen;
  int          irqs_seen;
  int          errors      = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  logic        rd_d        = 1'b0;
  logic [31:0] lfsr_ff     = 32'h7F69;
  logic [7:0]  exp_q[$];
  string       name_q[$];

  always #25 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) cyc <= cyc + 1;

  tbw_top tbw_top_inst (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .wt_tap_in(wt_tap_in),
    .prescaler_irq_out(prescaler_irq_out), .prescaler_irq_num_out(prescaler_irq_num_out),
    .cpu_reset_out(cpu_reset_out), .pre_taps_out(pre_taps_out), .wd_active_out(wd_active_out)
  );
  tbw_cpu_model tbw_cpu_model_inst (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .irq_in(prescaler_irq_out),
    .irq_num_in(prescaler_irq_num_out), .cpu_reset_in(cpu_reset_out),
    .wt_tap_out(wt_tap_in), .resets_seen_out(resets_seen), .irqs_seen_out(irqs_seen)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in    <= 1'b0;
  endtask

  // the expected value is queued; the monitor compares it when the data appear
  task automatic reg_read(input logic [1:0] a, input logic [7:0] e, input string n);
    exp_q.push_back(e);
    name_q.push_back(n);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in   <= 1'b0;
    @(posedge core_clk_in);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge core_clk_in) begin
    if (rd_d) begin
      check(name_q.pop_front(), {24'h000000, reg_rdata_out}, {24'h000000, exp_q.pop_front()});
    end
    rd_d <= reg_rd_in;
  end

  // waits for the reset pulse and checks it fell inside the window
  task automatic wait_fire(input int lo, input int hi, input string n);
    int t0;
    t0 = cyc;
    while (cpu_reset_out !== 1'b1 && cyc - t0 < hi + 20) begin
      @(posedge core_clk_in);
    end
    check(n, {31'h00000000, (cyc - t0 >= lo) && (cyc - t0 <= hi)}, 32'h00000001);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    logic [7:0]  rnd;
    logic [17:0] snap;
    idle(10);
    reset_in <= 1'b0;
    reg_read(tbw_pkg::ADDR_PRE_CTRL, 8'h00, "pre_ctrl_reset");
    reg_read(tbw_pkg::ADDR_SUB_CTRL, 8'h01, "sub_ctrl_reset");
    reg_read(tbw_pkg::ADDR_WD_CTRL, 8'h00, "wd_ctrl_reset");
    check("irq_num", {24'h000000, prescaler_irq_num_out}, 32'h00000010);
    for (int i = 0; i < 4; i++) begin
      lfsr_ff = lfsr_next(lfsr_ff);
      rnd = {5'h00, lfsr_ff[0], i[1:0]};
      reg_write(tbw_pkg::ADDR_PRE_CTRL, rnd);
      reg_read(tbw_pkg::ADDR_PRE_CTRL, rnd, "pre_ctrl_rw");
      reg_write(tbw_pkg::ADDR_WD_CTRL, {6'h00, i[1:0]});
      reg_read(tbw_pkg::ADDR_WD_CTRL, {6'h00, i[1:0]}, "wd_ctrl_rw");
    end
    // shortest interval: 2^12 clocks from the counter clear
    reg_write(tbw_pkg::ADDR_PRE_CTRL, 8'h14);
    idle(10);
    snap = pre_taps_out;
    idle(100);
    check("tap_rate", {14'h0000, pre_taps_out - snap}, 32'h00000032);
    idle(4096 - 130);
    reg_read(tbw_pkg::ADDR_PRE_CTRL, 8'h04, "flag_early_sel0");
    idle(30);
    reg_read(tbw_pkg::ADDR_PRE_CTRL, 8'h0C, "flag_set_sel0");
    check("irq_on", {31'h00000000, prescaler_irq_out}, 32'h00000001);
    // next interval 2^14; writing the flag as zero clears it
    reg_write(2'h3, 8'hFF);
    reg_write(tbw_pkg::ADDR_PRE_CTRL, 8'h15);
    idle(3);
    check("irq_off", {31'h00000000, prescaler_irq_out}, 32'h00000000);
    reg_read(2'h3, 8'h00, "count_high");
    idle(16384 - 40);
    reg_read(tbw_pkg::ADDR_PRE_CTRL, 8'h05, "flag_early_sel1");
    idle(40);
    reg_read(tbw_pkg::ADDR_PRE_CTRL, 8'h0D, "flag_set_sel1");
    reg_write(tbw_pkg::ADDR_PRE_CTRL, 8'h00);
    // watchdog from the prescaler, restarted before it runs out
    reg_write(tbw_pkg::ADDR_WD_CTRL, 8'h04);
    reg_read(tbw_pkg::ADDR_WD_CTRL, 8'h08, "wd_running");
    idle(10000);
    check("no_early_reset", resets_seen, 32'h00000000);
    reg_write(tbw_pkg::ADDR_WD_CTRL, 8'h04);
    wait_fire(14336, 18432, "wd_pre_window");
    idle(3);
    check("wd_stopped", {31'h00000000, wd_active_out}, 32'h00000000);
    // watchdog from the watch timer, taps scaled to 64 clocks
    reg_write(tbw_pkg::ADDR_SUB_CTRL, 8'h00);
    reg_read(tbw_pkg::ADDR_SUB_CTRL, 8'h00, "src_watch");
    reg_write(tbw_pkg::ADDR_WD_CTRL, 8'h04);
    wait_fire(7 * 64, 9 * 64, "wd_sub_window");
    idle(3);
    check("reset_count", resets_seen, 32'h00000002);
    check("irq_count", irqs_seen, 32'h00000002);
    tally_and_finish();
  end

  // the scenarios need about 50000 cycles
  initial begin
    #(60000 * 50);
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
